/* File: bench/mbhp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// Host bus model
// ----
module mbhp_host (
   input  wire logic       clk,
   input  wire logic [7:0] lower_out,
   input  wire logic       lower_oe_b,
   input  wire logic [7:0] upper_out,
   input  wire logic       upper_oe_b,
   output logic      [7:0] lower_in,
   output logic      [7:0] upper_in,
   output var logic        address_strobe_input,
   output var logic        write_control_input,
   output var logic        read_control_input,
   output var logic        code_select_input
);
   logic [7:0] h_lo = 8'h00;
   logic [7:0] h_hi = 8'h00;
   logic       h_en = 1'b0;
   // A released line shows the inverse of its last level, so a stale latch cannot pass.
   assign lower_in = !lower_oe_b ? lower_out : (h_en ? h_lo : ~h_lo);
   assign upper_in = !upper_oe_b ? upper_out : (h_en ? h_hi : ~h_hi);
   initial begin
      address_strobe_input = 1'b0;
      write_control_input = 1'b1;
      read_control_input = 1'b1;
      code_select_input = 1'b1;
   end
   task automatic addr(input logic [15:0] a);
      @(posedge clk);
      #2 {h_hi, h_lo} = a;
      h_en = 1'b1;
      address_strobe_input = 1'b1;
      repeat (4) @(posedge clk);
      #2 address_strobe_input = 1'b0;
      repeat (6) @(posedge clk);
      #2 h_en = 1'b0;
   endtask
   task automatic ctl(input logic w, input logic r, input logic c);
      @(posedge clk);
      #2 write_control_input = w;
      read_control_input = r;
      code_select_input = c;
   endtask
endmodule
`default_nettype wire

/* File: bench/mbhp_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// Bench
// ----
module mbhp_port_bench;
   logic                  clk = 1'b0;
   logic                  rst_b = 1'b0;
   wire logic [7:0]       lower_in, upper_in, lower_out, upper_out;
   wire logic             lower_oe_b, upper_oe_b, address_strobe_input;
   wire logic             write_control_input, read_control_input, code_select_input;
   mbhp_pkg::mbhp_bus_e   bus_mode = mbhp_pkg::MBHP_BUS_MUX;
   mbhp_pkg::mbhp_wr_e    wr_mode = mbhp_pkg::MBHP_WR_STROBE;
   mbhp_pkg::mbhp_rd_e    rd_mode = mbhp_pkg::MBHP_RD_STROBE;
   logic                  code_fetch_used = 1'b0;
   logic                  page_load = 1'b0;
   logic                  array_busy = 1'b0;
   logic [7:0]            page_value = 8'h00;
   mbhp_pkg::mbhp_sel_s   array_sel = '0;
   logic [15:0]           read_data = 16'h0000;
   mbhp_pkg::mbhp_terms_s logic_terms;
   int                    fails = 0;
   int                    n_compared = 0;
   wire logic [3:0]       flags = {lower_oe_b, logic_terms.rd, logic_terms.wr, logic_terms.code};
   always #12.5 clk = ~clk;
   mbhp_port i_mbhp_port (.clk, .rst_b, .lower_in, .lower_out, .lower_oe_b, .upper_in,
      .upper_out, .upper_oe_b, .address_strobe_input, .write_control_input,
      .read_control_input, .code_select_input, .bus_mode, .wr_mode, .rd_mode,
      .code_fetch_used, .page_load, .page_value, .array_sel, .read_data, .array_busy,
      .logic_terms);
   mbhp_host i_mbhp_host (.clk, .lower_out, .lower_oe_b, .upper_out, .upper_oe_b,
      .lower_in, .upper_in, .address_strobe_input, .write_control_input,
      .read_control_input, .code_select_input);
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Bounded wait; running out of cycles is reported and ends the run.
   task automatic wait_flag(input int i, input logic v);
      int k;
      for (k = 0; k < 20 && flags[i] !== v; k++) tick(1);
      chk("flag", 16'(v), 16'(flags[i]));
      if (k == 20) wrap_up();
   endtask
   task automatic s_reset();
      rst_b = 1'b0;
      tick(6);
      rst_b = 1'b1;
      tick(4);
      chk("lower_oe_b", 16'h0001, 16'(lower_oe_b));
      chk("upper_oe_b", 16'h0001, 16'(upper_oe_b));
      chk("page", 16'h0000, 16'(logic_terms.page));
   endtask
   task automatic s_latch(input mbhp_pkg::mbhp_bus_e m, input logic [15:0] a);
      bus_mode = m;
      i_mbhp_host.addr(a);
      tick(6);
      chk("addr", a, logic_terms.addr);
   endtask
   task automatic s_modes();
      wr_mode = mbhp_pkg::MBHP_WR_DIR;
      rd_mode = mbhp_pkg::MBHP_RD_ECLK;
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b1);
      wait_flag(2, 1'b1);
      i_mbhp_host.ctl(1'b0, 1'b1, 1'b1);
      wait_flag(1, 1'b1);
      wait_flag(2, 1'b0);
      i_mbhp_host.ctl(1'b0, 1'b0, 1'b1);
      wait_flag(1, 1'b0);
      rd_mode = mbhp_pkg::MBHP_RD_DSTROBE;
      i_mbhp_host.ctl(1'b1, 1'b0, 1'b1);
      wait_flag(2, 1'b1);
      i_mbhp_host.ctl(1'b0, 1'b0, 1'b1);
      wait_flag(1, 1'b1);
      wait_flag(2, 1'b0);
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b1);
      wr_mode = mbhp_pkg::MBHP_WR_STROBE;
      rd_mode = mbhp_pkg::MBHP_RD_STROBE;
      tick(6);
   endtask
   task automatic s_read(input mbhp_pkg::mbhp_bus_e m, input mbhp_pkg::mbhp_sel_s s,
                         input logic busy, input logic drive, input logic [15:0] d);
      bus_mode = m;
      array_sel = s;
      array_busy = busy;
      read_data = d;
      i_mbhp_host.ctl(1'b1, 1'b0, 1'b1);
      if (drive) begin
         wait_flag(3, 1'b0);
         chk("lower_out", 16'(d[7:0]), 16'(lower_out));
         chk("upper_oe_b", 16'(m == mbhp_pkg::MBHP_BUS_MUX), 16'(upper_oe_b));
         if (m != mbhp_pkg::MBHP_BUS_MUX) chk("upper_out", 16'(d[15:8]), 16'(upper_out));
         wait_flag(2, 1'b1);
      end else begin
         tick(10);
         chk("lower_oe_b", 16'h0001, 16'(lower_oe_b));
      end
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b1);
      wait_flag(3, 1'b1);
   endtask
   task automatic s_ctl();
      chk("gen_in", 16'h0001, 16'(logic_terms.gen_in));
      i_mbhp_host.ctl(1'b0, 1'b1, 1'b1);
      wait_flag(1, 1'b1);
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b1);
      wait_flag(1, 1'b0);
      code_fetch_used = 1'b1;
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b0);
      wait_flag(0, 1'b1);
      i_mbhp_host.ctl(1'b1, 1'b1, 1'b1);
   endtask
   task automatic s_page();
      page_value = 8'h7E;
      page_load = 1'b1;
      tick(1);
      page_load = 1'b0;
      tick(3);
      chk("page", 16'h007E, 16'(logic_terms.page));
   endtask
   initial begin
      s_reset();
      s_latch(mbhp_pkg::MBHP_BUS_MUX, 16'hA5C3);
      s_latch(mbhp_pkg::MBHP_BUS_BURST, 16'h3C5A);
      s_read(mbhp_pkg::MBHP_BUS_MUX, 4'h2, 1'b0, 1'b1, 16'h5A3C);
      s_read(mbhp_pkg::MBHP_BUS_MUX, 4'h0, 1'b0, 1'b0, 16'h1234);
      s_read(mbhp_pkg::MBHP_BUS_NONMUX, 4'h1, 1'b0, 1'b1, 16'hC396);
      s_read(mbhp_pkg::MBHP_BUS_MUX, 4'hC, 1'b1, 1'b0, 16'h0F0F);
      s_read(mbhp_pkg::MBHP_BUS_MUX, 4'h4, 1'b1, 1'b1, 16'h8E71);
      s_ctl();
      s_modes();
      s_page();
      s_reset();
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: shared/mbhp_pkg.sv */
package mbhp_pkg;

   // ------------------------------------------------------------
   // Widths and encodings
   // ------------------------------------------------------------
   localparam int BYTE_W  = 8;
   localparam int ADDR_W  = 16;
   localparam int PAGE_W  = 8;
   localparam int SEL_W   = 4;

   localparam logic [PAGE_W-1:0] PAGE_RST  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
   localparam logic [1:0]        SYNC_ONES = 2'h3;
   localparam logic [1:0]        SYNC_ZERO = 2'h0;

   // Bus flavour of the host: how the address is latched and whether the upper port is driven on reads.
   typedef enum logic [1:0] {
      MBHP_BUS_MUX,
      MBHP_BUS_NONMUX,
      MBHP_BUS_PAGED,
      MBHP_BUS_BURST
   } mbhp_bus_e;

   typedef enum logic {
      MBHP_WR_STROBE,
      MBHP_WR_DIR
   } mbhp_wr_e;

   typedef enum logic [1:0] {
      MBHP_RD_STROBE,
      MBHP_RD_ECLK,
      MBHP_RD_DSTROBE,
      MBHP_RD_CODE
   } mbhp_rd_e;

   // Terms handed to the decode and user logic arrays.
   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [ADDR_W-1:0] addr;
      logic              rd;
      logic              wr;
      logic              code;
      logic              gen_in;
   } mbhp_terms_s;

   // Selects returned by the decode logic array.
   typedef struct packed {
      logic primary;
      logic secondary;
      logic sram;
      logic regs;
   } mbhp_sel_s;

endpackage

/* File: src/mbhp_port.sv */
`timescale 1ns/100ps
`default_nettype none
module mbhp_port #(
   parameter int ADDR_W = mbhp_pkg::ADDR_W
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic [mbhp_pkg::BYTE_W-1:0] lower_in,
   output logic      [mbhp_pkg::BYTE_W-1:0] lower_out,
   output logic                             lower_oe_b,
   input  wire logic [mbhp_pkg::BYTE_W-1:0] upper_in,
   output logic      [mbhp_pkg::BYTE_W-1:0] upper_out,
   output logic                             upper_oe_b,
   input  wire logic                        address_strobe_input,
   input  wire logic                        write_control_input,
   input  wire logic                        read_control_input,
   input  wire logic                        code_select_input,
   input  wire mbhp_pkg::mbhp_bus_e         bus_mode,
   input  wire mbhp_pkg::mbhp_wr_e          wr_mode,
   input  wire mbhp_pkg::mbhp_rd_e          rd_mode,
   input  wire logic                        code_fetch_used,
   input  wire logic                        page_load,
   input  wire logic [mbhp_pkg::PAGE_W-1:0] page_value,
   input  wire mbhp_pkg::mbhp_sel_s         array_sel,
   input  wire logic [2*mbhp_pkg::BYTE_W-1:0] read_data,
   input  wire logic                        array_busy,
   output mbhp_pkg::mbhp_terms_s            logic_terms
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Three stages; a level changes only when stages two and three agree.
   logic [2:0] sy_as, sy_wr, sy_rd, sy_cs;
   logic       as_q, wr_q, rd_q, cs_q;
   logic       next_as_q, next_wr_q, next_rd_q, next_cs_q;

   always_comb begin
      next_as_q = (sy_as[1] == sy_as[2]) ? sy_as[2] : as_q;
      next_wr_q = (sy_wr[1] == sy_wr[2]) ? sy_wr[2] : wr_q;
      next_rd_q = (sy_rd[1] == sy_rd[2]) ? sy_rd[2] : rd_q;
      next_cs_q = (sy_cs[1] == sy_cs[2]) ? sy_cs[2] : cs_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sy_as <= 3'h0;
         sy_wr <= 3'h7;
         sy_rd <= 3'h7;
         sy_cs <= 3'h7;
         as_q  <= 1'b0;
         wr_q  <= 1'b1;
         rd_q  <= 1'b1;
         cs_q  <= 1'b1;
      end else begin
         sy_as <= {sy_as[1:0], address_strobe_input};
         sy_wr <= {sy_wr[1:0], write_control_input};
         sy_rd <= {sy_rd[1:0], read_control_input};
         sy_cs <= {sy_cs[1:0], code_select_input};
         as_q  <= next_as_q;
         wr_q  <= next_wr_q;
         rd_q  <= next_rd_q;
         cs_q  <= next_cs_q;
      end
   end

   // ------------------------------------------------------------
   // Control decoding
   // ------------------------------------------------------------
   logic rd_act, wr_act, code_act;

   // With a direction input the write is qualified by the read pin; an E clock
   // host qualifies on E high, every strobe host on its strobe low.
   always_comb begin
      wr_act = 1'b0;
      unique case (wr_mode)
         mbhp_pkg::MBHP_WR_STROBE: wr_act = !wr_q;
         mbhp_pkg::MBHP_WR_DIR: begin
            if (rd_mode == mbhp_pkg::MBHP_RD_ECLK) begin
               wr_act = !wr_q && rd_q;
            end else begin
               wr_act = !wr_q && !rd_q;
            end
         end
      endcase
      code_act = code_fetch_used && !cs_q;
      rd_act   = 1'b0;
      unique case (rd_mode)
         mbhp_pkg::MBHP_RD_STROBE:  rd_act = !rd_q;
         mbhp_pkg::MBHP_RD_ECLK:    rd_act = rd_q && (wr_mode == mbhp_pkg::MBHP_WR_DIR) && wr_q;
         mbhp_pkg::MBHP_RD_DSTROBE: rd_act = !rd_q && wr_q;
         mbhp_pkg::MBHP_RD_CODE:    rd_act = !rd_q;
      endcase
      if (code_act) begin
         rd_act = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Address latch and page register
   // ------------------------------------------------------------
   // The multiplexed latch is transparent while the strobe is high, so
   // the address is frozen on the falling edge and held for the cycle.
   logic [ADDR_W-1:0]           addr, next_addr;
   logic [mbhp_pkg::PAGE_W-1:0] page, next_page;

   always_comb begin
      next_addr = addr;
      if (bus_mode == mbhp_pkg::MBHP_BUS_NONMUX) begin
         next_addr = ADDR_W'({upper_in, lower_in});
      end else if (as_q) begin
         next_addr = ADDR_W'({upper_in, lower_in});
      end
      next_page = page;
      if (page_load) begin
         next_page = page_value;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         addr <= ADDR_W'(mbhp_pkg::ADDR_RST);
         page <= mbhp_pkg::PAGE_RST;
      end else begin
         addr <= next_addr;
         page <= next_page;
      end
   end

   // ------------------------------------------------------------
   // Terms to the logic arrays and read drive
   // ------------------------------------------------------------
   // A busy array still answers reads of the other one: busy gates
   // the drive only when primary and secondary are both selected.
   mbhp_pkg::mbhp_terms_s next_terms;
   logic                  any_sel, drive, next_drive;
   logic [2*mbhp_pkg::BYTE_W-1:0] next_data, data_q;

   always_comb begin
      next_terms.page   = page;
      next_terms.addr   = 16'(addr);
      next_terms.rd     = rd_act;
      next_terms.wr     = wr_act;
      next_terms.code   = code_act;
      next_terms.gen_in = !code_fetch_used && cs_q;
      any_sel = array_sel.primary || array_sel.secondary
             || array_sel.sram || array_sel.regs;
      next_drive = rd_act && any_sel && !as_q;
      next_data  = read_data;
      if (array_busy && array_sel.primary && array_sel.secondary) begin
         next_drive = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         logic_terms <= '0;
         drive       <= 1'b0;
         data_q      <= 16'h0000;
         lower_oe_b  <= 1'b1;
         upper_oe_b  <= 1'b1;
         lower_out   <= 8'h00;
         upper_out   <= 8'h00;
      end else begin
         logic_terms <= next_terms;
         drive       <= next_drive;
         data_q      <= next_data;
         lower_oe_b  <= !next_drive;
         upper_oe_b  <= !(next_drive && bus_mode != mbhp_pkg::MBHP_BUS_MUX);
         lower_out   <= next_data[mbhp_pkg::BYTE_W-1:0];
         upper_out   <= next_data[2*mbhp_pkg::BYTE_W-1:mbhp_pkg::BYTE_W];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_read_sel;
      rd_act && any_sel && !as_q && !array_busy;
   endsequence

   sequence s_strobe_seen;
      sy_as[1] && sy_as[2];
   endsequence

   sequence s_busy_both;
      array_busy && array_sel.primary && array_sel.secondary;
   endsequence

   sequence s_code_fetch;
      code_fetch_used && !cs_q;
   endsequence

   AST_STROBE_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
      as_q |=> lower_oe_b)
      else $error("Port driven while address strobe active.");

   AST_BUSY_REFUSE: assert property (@(posedge clk) disable iff (!rst_b)
      s_busy_both |=> lower_oe_b)
      else $error("Port driven while both flash arrays busy.");

   AST_UPPER_MUX_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_mode == mbhp_pkg::MBHP_BUS_MUX) |=> upper_oe_b)
      else $error("Upper port driven in multiplexed mode.");

   AST_UPPER_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_mode != mbhp_pkg::MBHP_BUS_MUX) |=> upper_oe_b == lower_oe_b)
      else $error("Upper and lower drive disagree.");

   AST_DATA_OUT: assert property (@(posedge clk) disable iff (!rst_b)
      drive |-> !lower_oe_b && lower_out == data_q[7:0] && upper_out == data_q[15:8])
      else $error("Driven data does not match read data.");

   AST_STROBE_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
      as_q |=> addr == $past(ADDR_W'({upper_in, lower_in})))
      else $error("Address not captured during strobe.");

   AST_NONMUX_FOLLOW: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_mode == mbhp_pkg::MBHP_BUS_NONMUX) |=> addr == $past(ADDR_W'({upper_in, lower_in})))
      else $error("Address does not follow pins in non-multiplexed mode.");

   AST_AS_SYNC: assert property (@(posedge clk) disable iff (!rst_b)
      s_strobe_seen |=> as_q)
      else $error("Agreed strobe level not taken.");

   AST_AS_GLITCH: assert property (@(posedge clk) disable iff (!rst_b)
      (sy_as[1] != sy_as[2]) |=> $stable(as_q))
      else $error("Strobe level moved on disagreeing stages.");

   AST_RD_TERM: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_mode == mbhp_pkg::MBHP_RD_STROBE && !rd_q) |=> logic_terms.rd)
      else $error("Read strobe missing from logic terms.");

   AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_mode == mbhp_pkg::MBHP_RD_STROBE && rd_q && !code_act) |=> !logic_terms.rd)
      else $error("Read term set without read strobe.");

   AST_WR_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_mode == mbhp_pkg::MBHP_WR_STROBE && wr_q) |=> !logic_terms.wr)
      else $error("Write term set without write strobe.");

   AST_ECLK_READ: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_mode == mbhp_pkg::MBHP_RD_ECLK && wr_mode == mbhp_pkg::MBHP_WR_DIR && rd_q && wr_q)
      |=> logic_terms.rd)
      else $error("E clock read not seen.");

   AST_DIR_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_mode == mbhp_pkg::MBHP_WR_DIR && rd_mode == mbhp_pkg::MBHP_RD_ECLK && !wr_q && rd_q)
      |=> logic_terms.wr)
      else $error("Direction write not seen.");

   AST_CODE_GEN: assert property (@(posedge clk) disable iff (!rst_b)
      s_code_fetch |=> !logic_terms.gen_in)
      else $error("Fetch strobe leaked into generic input.");

   AST_GEN_INPUT: assert property (@(posedge clk) disable iff (!rst_b)
      !code_fetch_used |=> logic_terms.gen_in == $past(cs_q) && !logic_terms.code)
      else $error("Generic input not passed to logic arrays.");

   AST_PAGE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !page_load |=> $stable(page))
      else $error("Page register moved without load.");

   AST_OUT_RESET: assert property (@(posedge clk)
      !rst_b |=> lower_out == 8'h00 && upper_out == 8'h00)
      else $error("Reset did not clear port data.");

   AST_DRIVE_ON_READ: assert property (@(posedge clk) disable iff (!rst_b)
      s_read_sel |=> !lower_oe_b)
      else $error("Lower port not driven on selected read.");

   AST_NO_DRIVE_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      !rd_act |=> lower_oe_b)
      else $error("Lower port driven without read.");

   AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      (!as_q && bus_mode != mbhp_pkg::MBHP_BUS_NONMUX) |=> $stable(addr))
      else $error("Latched address moved outside strobe.");

   AST_ADDR_TERMS: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> logic_terms.addr == $past(addr))
      else $error("Address not passed to logic arrays.");

   AST_WR_TERM: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_mode == mbhp_pkg::MBHP_WR_STROBE && !wr_q) |=> logic_terms.wr)
      else $error("Write strobe missing from logic terms.");

   AST_CODE_READ: assert property (@(posedge clk) disable iff (!rst_b)
      (code_fetch_used && !cs_q) |=> logic_terms.rd && logic_terms.code)
      else $error("Code fetch not treated as read.");

   AST_PAGE_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
      page_load |=> ##1 logic_terms.page == $past(page_value, 2))
      else $error("Page register not loaded.");

   AST_RESET_CLEAR: assert property (@(posedge clk)
      !rst_b |=> lower_oe_b && upper_oe_b && logic_terms == '0)
      else $error("Reset did not clear outputs.");

endmodule
`default_nettype wire
